// ---- core/dtf_regs.vh ----
// Register map, field positions and reset values of the delay timer block
// What this block does
// [R1] Trigger rise starts on-delay timing
// [R2] Trigger held through on-delay sets output
// [R3] Early trigger fall cancels on-delay
// [R4] Trigger fall starts off-delay timing
// [R5] Trigger held low through off-delay clears output
// [R6] Early trigger rise cancels off-delay
// [R7] Retentive option keeps state over power loss
// [R8] Durations may come from another block's count
// [R9] Retentive delay counts from rise, then sets output
// [R10] Further triggers leave running count unchanged
// [R11] Clear input alone zeroes output and count
// [R12] Clear input overrides trigger
// [R13] Non-retentive block restarts cleared after power loss
// [R14] Wiping relay trigger sets output, starts count
// [R15] Wiping relay clears output at duration
// [R16] Wiping relay trigger fall clears output at once
// [R17] Retentive option off after reset
// [R18] Edges by previous-sample compare; ticks count time
`ifndef DTF_REGS_VH
`define DTF_REGS_VH
// Byte offsets
`define DTF_CTRL      8'h00
`define DTF_TICKDIV   8'h04
`define DTF_ON_T      8'h08
`define DTF_OFF_T     8'h0c
`define DTF_RTD_T     8'h10
`define DTF_WIPE_T    8'h14
`define DTF_REFSEL    8'h18
`define DTF_STATUS    8'h1c
`define DTF_CNT_OO    8'h20
`define DTF_CNT_RTD   8'h24
`define DTF_CNT_WIPE  8'h28
// CTRL fields: retentive option per block
`define DTF_RET_OO    0
`define DTF_RET_RTD   1
`define DTF_RET_WIPE  2
`define DTF_CTRL_RST  3'h0
// REFSEL: 3 bits per duration, bit 0 use reference, bits 2:1 block number
`define DTF_REF_W     3
`define DTF_REF_ON    0
`define DTF_REF_OFF   3
`define DTF_REF_RTD   6
`define DTF_REF_WIPE  9
`define DTF_REFSEL_RST 12'h000
// Block numbers used as reference sources
`define DTF_BLK_OO    2'h0
`define DTF_BLK_RTD   2'h1
`define DTF_BLK_WIPE  2'h2
// STATUS fields
`define DTF_ST_Q_OO    0
`define DTF_ST_Q_RTD   1
`define DTF_ST_Q_WIPE  2
`define DTF_ST_RUN_ON  3
`define DTF_ST_RUN_OFF 4
`define DTF_ST_RUN_RTD 5
// Duration reset value, in ticks
`define DTF_DUR_RST   16'h000a
`endif

// ---- core/dtf_sync.v ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dtf_sync #(
  parameter W = 1
) (
  // Clock, reset, enable
  input  wire         clk,
  input  wire         reset,
  input  wire         ce,
  // Raw and synchronised levels
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta; // First stage, read only by dout

  // Two stages; held while the clock enable is low
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else if (ce) begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ---- core/dtf_timers.v ----
// On/off-delay, retentive on-delay and wiping relay with AHB-Lite registers
`timescale 1ns/1ps
`include "dtf_regs.vh"
module dtf_timers #(
  parameter CW      = 16,      // Elapsed count width
  parameter TICKDIV = 40000    // Clocks per tick, 1 ms at 40 MHz
) (
  // Clock, reset, enable
  input  wire        clk,
  input  wire        reset,
  input  wire        ce,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Trigger, clear and power-restore pins
  input  wire        trg_onoff,
  input  wire        trg_rtd,
  input  wire        clr_rtd,
  input  wire        trg_wipe,
  input  wire        power_restore,
  // Block outputs
  output reg         q_onoff,
  output reg         q_rtd,
  output reg         q_wipe
);
  // Configuration registers
  reg [2:0]    ctrl;           // Retentive options
  reg [31:0]   tick_div;       // Clocks per time-base tick
  reg [CW-1:0] on_t;           // On-delay constant
  reg [CW-1:0] off_t;          // Off-delay constant
  reg [CW-1:0] rtd_t;          // Retentive delay constant
  reg [CW-1:0] wipe_t;         // Wiping pulse constant
  reg [11:0]   refsel;         // Reference source selects
  // Timer state
  reg [CW-1:0] elapsed_oo;     // On/off-delay elapsed_count
  reg [CW-1:0] elapsed_rtd;    // Retentive elapsed_count
  reg [CW-1:0] elapsed_wipe;   // Wiping relay elapsed_count
  reg          run_on;         // On-delay timing
  reg          run_off;        // Off-delay timing
  reg          run_rtd;        // Retentive delay timing
  reg [3:0]    prev;           // Previous trigger and power pin samples
  reg [31:0]   pre_cnt;        // Tick prescaler
  reg          tick;           // One-cycle time-base pulse
  // Bus data-phase state
  reg          dp_wr;          // Write pending
  reg [7:0]    dp_addr;        // Latched address
  // Synchronised pins
  wire [4:0]   pins;
  wire         s_trg_oo  = pins[0];
  wire         s_trg_rtd = pins[1];
  wire         s_clr_rtd = pins[2];
  wire         s_trg_wp  = pins[3];
  wire         s_pwr     = pins[4];
  wire         pwr_rise;
  wire [CW-1:0] dur_on;
  wire [CW-1:0] dur_off;
  wire [CW-1:0] dur_rtd;
  wire [CW-1:0] dur_wipe;
  wire         addr_ok;
  reg  [31:0]  next_rdata;

  // Pick a constant or the elapsed count of any of the three blocks, its own included
  function [CW-1:0] pick;
    input [2:0]    sel;
    input [CW-1:0] konst;
    input [CW-1:0] c0;
    input [CW-1:0] c1;
    input [CW-1:0] c2;
    begin
      if (!sel[0]) begin
        pick = konst;
      end else begin
        case (sel[2:1])
          `DTF_BLK_OO:   pick = c0;
          `DTF_BLK_RTD:  pick = c1;
          `DTF_BLK_WIPE: pick = c2;
          default:       pick = konst;
        endcase
      end
    end
  endfunction

  // True once a count, advanced by this tick, meets its limit
  function reached;
    input [CW-1:0] cnt;
    input [CW-1:0] lim;
    begin
      reached = ({1'b0, cnt} + {{CW{1'b0}}, 1'b1}) >= {1'b0, lim};
    end
  endfunction

  // Elapsed count advanced by one tick; wraps silently at the top
  function [CW-1:0] bump;
    input [CW-1:0] cnt;
    begin
      bump = cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  // Pins come from outside the clock domain
  dtf_sync #(
    .W (5)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .din   ({power_restore, trg_wipe, clr_rtd, trg_rtd, trg_onoff}),
    .dout  (pins)
  );

  // Duration sources
  assign dur_on   = pick(refsel[`DTF_REF_ON+:`DTF_REF_W], on_t, elapsed_oo, elapsed_rtd, elapsed_wipe);    // R8
  assign dur_off  = pick(refsel[`DTF_REF_OFF+:`DTF_REF_W], off_t, elapsed_oo, elapsed_rtd, elapsed_wipe);  // R8
  assign dur_rtd  = pick(refsel[`DTF_REF_RTD+:`DTF_REF_W], rtd_t, elapsed_oo, elapsed_rtd, elapsed_wipe);  // R8
  assign dur_wipe = pick(refsel[`DTF_REF_WIPE+:`DTF_REF_W], wipe_t, elapsed_oo, elapsed_rtd, elapsed_wipe); // R8

  // Power restore seen as a rise of the synchronised pin
  assign pwr_rise = s_pwr & ~prev[3];

  // Slave always ready unless frozen; errors never signalled
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & hready & htrans[1];

  // Time base prescaler
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_cnt <= 32'h0;
      tick    <= 1'b0;
    end else if (ce) begin
      if (pre_cnt + 32'h1 >= tick_div) begin
        pre_cnt <= 32'h0;
        tick    <= 1'b1; // R18
      end else begin
        pre_cnt <= pre_cnt + 32'h1;
        tick    <= 1'b0;
      end
    end
  end

  // Trigger and power pin history for edge detection
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      prev <= 4'h0;
    end else if (ce) begin
      prev <= {s_pwr, s_trg_wp, s_trg_rtd, s_trg_oo}; // R18
    end
  end

  // On/off-delay block
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      q_onoff    <= 1'b0;
      run_on     <= 1'b0;
      run_off    <= 1'b0;
      elapsed_oo <= {CW{1'b0}};
    end else if (ce) begin
      if (pwr_rise && !ctrl[`DTF_RET_OO]) begin
        // Volatile state lost over power failure
        q_onoff    <= 1'b0; // R7
        run_on     <= 1'b0;
        run_off    <= 1'b0;
        elapsed_oo <= {CW{1'b0}};
      end else if (s_trg_oo && !prev[0]) begin
        run_on     <= 1'b1; // R1
        run_off    <= 1'b0; // R6
        elapsed_oo <= {CW{1'b0}};
      end else if (!s_trg_oo && prev[0]) begin
        run_on     <= 1'b0; // R3
        run_off    <= q_onoff; // R4
        elapsed_oo <= {CW{1'b0}};
      end else if (run_on && tick) begin
        // Held high: count toward the on-delay
        if (reached(elapsed_oo, dur_on)) begin
          q_onoff <= 1'b1; // R2
          run_on  <= 1'b0;
        end
        elapsed_oo <= bump(elapsed_oo);
      end else if (run_off && tick) begin
        // Held low: count toward the off-delay
        if (reached(elapsed_oo, dur_off)) begin
          q_onoff <= 1'b0; // R5
          run_off <= 1'b0;
        end
        elapsed_oo <= bump(elapsed_oo);
      end
    end
  end

  // Retentive on-delay block; clear wins over everything else
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      q_rtd       <= 1'b0;
      run_rtd     <= 1'b0;
      elapsed_rtd <= {CW{1'b0}};
    end else if (ce) begin
      if (s_clr_rtd) begin
        q_rtd       <= 1'b0; // R11 R12
        run_rtd     <= 1'b0;
        elapsed_rtd <= {CW{1'b0}};
      end else if (pwr_rise && !ctrl[`DTF_RET_RTD]) begin
        q_rtd       <= 1'b0; // R13
        run_rtd     <= 1'b0;
        elapsed_rtd <= {CW{1'b0}};
      end else if (s_trg_rtd && !prev[1] && !run_rtd && !q_rtd) begin
        run_rtd <= 1'b1; // R9 R10
      end else if (run_rtd && tick) begin
        // Trigger level no longer matters once started
        if (reached(elapsed_rtd, dur_rtd)) begin
          q_rtd   <= 1'b1; // R9
          run_rtd <= 1'b0;
        end
        elapsed_rtd <= bump(elapsed_rtd);
      end
    end
  end

  // Wiping relay block
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      q_wipe       <= 1'b0;
      elapsed_wipe <= {CW{1'b0}};
    end else if (ce) begin
      if (pwr_rise && !ctrl[`DTF_RET_WIPE]) begin
        q_wipe       <= 1'b0; // R7
        elapsed_wipe <= {CW{1'b0}};
      end else if (s_trg_wp && !prev[2]) begin
        q_wipe       <= 1'b1; // R14
        elapsed_wipe <= {CW{1'b0}};
      end else if (!s_trg_wp && prev[2]) begin
        q_wipe <= 1'b0; // R16
      end else if (q_wipe && tick) begin
        // Pulse ends when the count meets the duration
        if (reached(elapsed_wipe, dur_wipe)) begin
          q_wipe <= 1'b0; // R15
        end
        elapsed_wipe <= bump(elapsed_wipe);
      end
    end
  end

  // Address phase capture
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else if (ce && hready) begin
      dp_wr   <= addr_ok & hwrite;
      dp_addr <= haddr;
    end
  end

  // Register writes in the data phase; sizes other than word treated as word
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl     <= `DTF_CTRL_RST; // R17
      tick_div <= TICKDIV;
      on_t     <= `DTF_DUR_RST;
      off_t    <= `DTF_DUR_RST;
      rtd_t    <= `DTF_DUR_RST;
      wipe_t   <= `DTF_DUR_RST;
      refsel   <= `DTF_REFSEL_RST;
    end else if (ce && dp_wr) begin
      case (dp_addr)
        `DTF_CTRL:    ctrl     <= hwdata[2:0]; // R7
        `DTF_TICKDIV: tick_div <= hwdata;
        `DTF_ON_T:    on_t     <= hwdata[CW-1:0];
        `DTF_OFF_T:   off_t    <= hwdata[CW-1:0];
        `DTF_RTD_T:   rtd_t    <= hwdata[CW-1:0];
        `DTF_WIPE_T:  wipe_t   <= hwdata[CW-1:0];
        `DTF_REFSEL:  refsel   <= hwdata[11:0]; // R8
        default:      ctrl     <= ctrl; // Read-only or unmapped: ignored
      endcase
    end
  end

  // Read mux, sampled at the address phase
  always @* begin
    next_rdata = 32'h0;
    case (haddr)
      `DTF_CTRL:     next_rdata[2:0] = ctrl;
      `DTF_TICKDIV:  next_rdata = tick_div;
      `DTF_ON_T:     next_rdata[CW-1:0] = on_t;
      `DTF_OFF_T:    next_rdata[CW-1:0] = off_t;
      `DTF_RTD_T:    next_rdata[CW-1:0] = rtd_t;
      `DTF_WIPE_T:   next_rdata[CW-1:0] = wipe_t;
      `DTF_REFSEL:   next_rdata[11:0] = refsel;
      `DTF_STATUS: begin
        next_rdata[`DTF_ST_Q_OO]    = q_onoff;
        next_rdata[`DTF_ST_Q_RTD]   = q_rtd;
        next_rdata[`DTF_ST_Q_WIPE]  = q_wipe;
        next_rdata[`DTF_ST_RUN_ON]  = run_on;
        next_rdata[`DTF_ST_RUN_OFF] = run_off;
        next_rdata[`DTF_ST_RUN_RTD] = run_rtd;
      end
      `DTF_CNT_OO:   next_rdata[CW-1:0] = elapsed_oo;
      `DTF_CNT_RTD:  next_rdata[CW-1:0] = elapsed_rtd;
      `DTF_CNT_WIPE: next_rdata[CW-1:0] = elapsed_wipe;
      default:       next_rdata = 32'h0; // Unmapped reads zero
    endcase
  end

  // Read data register; stands through the data phase
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0;
    end else if (ce && addr_ok && !hwrite) begin
      hrdata <= next_rdata;
    end
  end
endmodule

// ---- verif/dtf_pin_src.sv ----
// Pin source standing in for upstream blocks and input terminals
`timescale 1ns/1ps
module dtf_pin_src (
  // Clock and reset
  input  logic       clk,
  input  logic       reset,
  // Requested levels: onoff, rtd, clear, wipe, power
  input  logic [4:0] req,
  // Pin levels
  output logic       trg_onoff,
  output logic       trg_rtd,
  output logic       clr_rtd,
  output logic       trg_wipe,
  output logic       power_restore
);
  // Levels change only just after an edge, like a clocked upstream block
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {power_restore, trg_wipe, clr_rtd, trg_rtd, trg_onoff} <= 5'h00;
    end else begin
      {power_restore, trg_wipe, clr_rtd, trg_rtd, trg_onoff} <= req;
    end
  end
endmodule

// ---- verif/dtf_timers_asserts.sv ----
// Port checker for the delay timer block
`timescale 1ns/1ps
module dtf_timers_asserts (
  // Clock and reset
  input logic clk,
  input logic reset,
  // Pins and outputs
  input logic trg_onoff,
  input logic trg_rtd,
  input logic clr_rtd,
  input logic trg_wipe,
  input logic power_restore,
  input logic q_onoff,
  input logic q_rtd,
  input logic q_wipe
);
  // Recent pin history, bit 0 newest; covers the sync latency
  logic [5:0] h_on, h_clr, h_pwr;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      h_on <= 6'h00;
      h_clr <= 6'h00;
      h_pwr <= 6'h00;
    end else begin
      h_on <= {h_on[4:0], trg_onoff};
      h_clr <= {h_clr[4:0], clr_rtd};
      h_pwr <= {h_pwr[4:0], power_restore};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Trigger dropped and held low
  sequence s_wipe_low;
    $fell(trg_wipe) ##1 !trg_wipe [*5];
  endsequence
  property p_wipe_fall; s_wipe_low |-> !q_wipe; endproperty
  a_wipe_fall: assert property (p_wipe_fall) else $error("wipe output outlived its trigger");
  property p_wipe_rise; $rose(trg_wipe) |-> ##[2:6] $rose(q_wipe); endproperty
  a_wipe_rise: assert property (p_wipe_rise) else $error("wipe output did not follow trigger");
  property p_on_set; $rose(q_onoff) |-> |h_on; endproperty
  a_on_set: assert property (p_on_set) else $error("delay output set with trigger low");
  property p_off_clr; $fell(q_onoff) |-> !(&h_on) || |h_pwr; endproperty
  a_off_clr: assert property (p_off_clr) else $error("delay output cleared with trigger high");
  property p_clr_hold; clr_rtd [*6] |-> !q_rtd; endproperty
  a_clr_hold: assert property (p_clr_hold) else $error("clear did not zero retentive output");
  property p_clr_wins; clr_rtd [*4] |-> !$rose(q_rtd); endproperty
  a_clr_wins: assert property (p_clr_wins) else $error("retentive output set under clear");
  property p_rtd_keep; $fell(q_rtd) |-> |h_clr || |h_pwr; endproperty
  a_rtd_keep: assert property (p_rtd_keep) else $error("retentive output fell without clear");
  property p_edge_only; trg_wipe [*8] |-> !$rose(q_wipe); endproperty
  a_edge_only: assert property (p_edge_only) else $error("wipe output set by a level");
endmodule
bind dtf_timers dtf_timers_asserts u_dtf_timers_asserts (.clk(clk), .reset(reset), .trg_onoff(trg_onoff),
  .trg_rtd(trg_rtd), .clr_rtd(clr_rtd), .trg_wipe(trg_wipe), .power_restore(power_restore),
  .q_onoff(q_onoff), .q_rtd(q_rtd), .q_wipe(q_wipe));

// ---- verif/tb_dtf_timers.sv ----
// Self-checking bench for the delay timer block
`timescale 1ns/1ps
`include "dtf_regs.vh"
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module tb_dtf_timers;
  logic        clk, reset, hsel, hwrite;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, rd;
  logic [4:0]  req;
  logic        ret;
  wire         hreadyout, hresp, trg_onoff, trg_rtd, clr_rtd, trg_wipe, power_restore, q_onoff, q_rtd, q_wipe;
  wire  [31:0] hrdata;
  wire  [2:0]  q = {q_wipe, q_rtd, q_onoff};
  int          failures, checks_done, seed, n, d;
  // Short tick so each tested duration is 8 to 28 clocks
  dtf_timers #(.CW(16), .TICKDIV(4)) u_dtf_timers (.clk(clk), .reset(reset), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trg_onoff(trg_onoff), .trg_rtd(trg_rtd),
    .clr_rtd(clr_rtd), .trg_wipe(trg_wipe), .power_restore(power_restore), .q_onoff(q_onoff),
    .q_rtd(q_rtd), .q_wipe(q_wipe));
  dtf_pin_src u_dtf_pin_src (.clk(clk), .reset(reset), .req(req), .trg_onoff(trg_onoff), .trg_rtd(trg_rtd),
    .clr_rtd(clr_rtd), .trg_wipe(trg_wipe), .power_restore(power_restore));
  // 40 MHz clock
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // Expected span of a duration in clocks, allowing tick phase and sync delay
  function automatic bit in_win(int c, int t);
    return c >= 4 * t - 4 && c <= 4 * t + 7;
  endfunction
  // One single AHB-Lite transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Ask the pin source for a level
  task automatic pin(input int i, input logic v);
    @(posedge clk);
    req[i] <= v;
  endtask
  // Cycles until output i shows v
  task automatic meas(input int i, input logic v, output int c);
    c = 0;
    while (q[i] !== v && c < 200) begin
      @(posedge clk);
      c++;
    end
  endtask
  // Cycles in which output i left level v
  task automatic hold(input int i, input logic v, input int cyc, output int b);
    b = 0;
    repeat (cyc) begin
      @(posedge clk);
      if (q[i] !== v) b++;
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    end_sim();
  end
  initial begin
    seed = 67062;
    reset = 1'b1;
    {hsel, hwrite, haddr, htrans, hwdata, req} = 49'h0;
    failures = 0;
    checks_done = 0;
    hsize = 3'h2;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    bus(0, `DTF_CTRL, 0); `CHK("ctrl", 32'h0, rd)
    bus(0, `DTF_ON_T, 0); `CHK("on_t", 32'h0000000a, rd)
    bus(0, 8'h3c, 0); `CHK("unmapped", 32'h0, rd)
    // Retentive delay takes its duration from the on/off block's count
    bus(1, `DTF_REFSEL, 32'h1 << `DTF_REF_RTD);
    bus(0, `DTF_REFSEL, 0); `CHK("refsel", 32'h1 << `DTF_REF_RTD, rd)
    `CHK("hresp", 1'b0, hresp)
    repeat (4) begin
      d = 2 + {$random(seed)} % 6;
      ret = $random(seed);
      // Own retentive constant is off by four ticks; only the reference gives d
      bus(1, `DTF_ON_T, d); bus(1, `DTF_OFF_T, d); bus(1, `DTF_RTD_T, d + 4); bus(1, `DTF_WIPE_T, d);
      bus(0, `DTF_OFF_T, 0); `CHK("off_t", d, rd)
      // On-delay cut short
      pin(0, 1); repeat (d) @(posedge clk); pin(0, 0);
      hold(0, 0, 4 * d + 8, n); `CHK("on_cancel", 0, n)
      pin(0, 1); meas(0, 1, n); `CHK("on_span", 1'b1, in_win(n, d))
      bus(0, `DTF_STATUS, 0); `CHK("status_q", 1'b1, rd[0])
      // Off-delay cut short, then completed
      pin(0, 0); repeat (d) @(posedge clk); pin(0, 1);
      hold(0, 1, 4 * d + 8, n); `CHK("off_cancel", 0, n)
      pin(0, 0); meas(0, 0, n); `CHK("off_span", 1'b1, in_win(n, d))
      bus(0, `DTF_CNT_OO, 0); `CHK("cnt_oo", d, rd)
      // Retentive delay with a retrigger mid-run
      pin(1, 1); pin(1, 0); repeat (2 * d) @(posedge clk); pin(1, 1); pin(1, 0);
      meas(1, 1, n); `CHK("rtd_span", 1'b1, in_win(n + 2 * d + 3, d))
      pin(1, 1); pin(2, 1); meas(1, 0, n); `CHK("clr_fast", 1'b1, n <= 8)
      hold(1, 0, 4 * d + 8, n); `CHK("clr_wins", 0, n)
      pin(2, 0); pin(1, 0);
      // Power loss with the retentive option on or off
      bus(1, `DTF_CTRL, {30'h0, ret, 1'b0});
      pin(1, 1); pin(1, 0); meas(1, 1, n); `CHK("rtd_set", 1'b1, in_win(n + 2, d))
      pin(4, 1); pin(4, 0); repeat (8) @(posedge clk); `CHK("retain", ret, q[1])
      pin(2, 1); meas(1, 0, n); pin(2, 0);
      // Wiping relay: full pulse, then early release
      pin(3, 1); meas(2, 1, n); `CHK("wipe_set", 1'b1, n <= 6)
      meas(2, 0, n); `CHK("wipe_span", 1'b1, in_win(n, d))
      pin(3, 0); pin(3, 1); meas(2, 1, n); `CHK("wipe_again", 1'b1, n <= 6)
      pin(3, 0);
      meas(2, 0, n); `CHK("wipe_drop", 1'b1, n <= 6)
    end
    end_sim();
  end
endmodule
